// *** ddc_ctrl.sv ***
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "ddc_map.svh"
module ddc_ctrl #(
	parameter int DQ_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic [7:0]        sw_addr,
	input  wire logic [31:0]       sw_wdata,
	input  wire logic              sw_wr,
	input  wire logic              sw_rd,
	output      logic [31:0]       sw_rdata,
	output      logic              ddr_ck,
	output      logic              ddr_cke,
	output      logic              ddr_cs_n,
	output      logic              ddr_ras_n,
	output      logic              ddr_cas_n,
	output      logic              ddr_we_n,
	output      logic [2:0]        ddr_ba,
	output      logic [13:0]       ddr_addr,
	output      logic              ddr_odt,
	input  wire logic [DQ_W-1:0]   ddr_dq_i,
	output      logic [DQ_W-1:0]   ddr_dq_o,
	output      logic              ddr_dq_oe
);
	if (DQ_W != 4 && DQ_W != 8 && DQ_W != 16) begin : g_dq_w_check
		$error("DQ_W must be 4, 8 or 16.");
	end

	ddc_pkg::ddc_regs_t r_reg;
	ddc_pkg::ddc_regs_t r_next;
	logic               tick;
	logic               bc4;
	logic [2:0]         last_beat;
	logic               busy;

	// Busy also covers a started operation that the sequencer has not yet picked up.
	assign busy      = r_reg.st != ddc_pkg::DDC_IDLE || r_reg.op != 3'h0;
	assign tick      = r_reg.ck;
	assign bc4       = r_reg.cfg[`DDC_CFG_BC4_BIT];
	assign last_beat = bc4 ? 3'h3 : 3'h7;

	always_comb begin
		r_next = r_reg;
		r_next.rdata = 32'h0;
		r_next.ck = ~r_reg.ck;
		r_next.s1 = ddr_dq_i[0];
		r_next.s2 = r_reg.s1;
		if (sw_rd) begin
			unique case (sw_addr)
				`DDC_OFS_CTRL: r_next.rdata = {29'h0, r_reg.op};
				`DDC_OFS_CFG: r_next.rdata = r_reg.cfg;
				`DDC_OFS_MRS: r_next.rdata = {15'h0, r_reg.mrs};
				`DDC_OFS_STATUS: r_next.rdata = {13'h0, r_reg.pass, r_reg.cap,
					r_reg.ok, r_reg.mpr_on, busy};
				default: r_next.rdata = 32'h0;
			endcase
		end
		if (sw_wr && !busy) begin
			unique case (sw_addr)
				`DDC_OFS_CTRL: r_next.op = sw_wdata[2:0];
				`DDC_OFS_CFG: r_next.cfg = sw_wdata;
				`DDC_OFS_MRS: r_next.mrs = sw_wdata[16:0];
				default: r_next.op = r_reg.op;
			endcase
		end
		// Capture of a returning burst, one beat per clock, via two sync flops.
		if (r_reg.cap_dly != 6'h0) begin
			r_next.cap_dly = r_reg.cap_dly - 6'h1;
			if (r_reg.cap_dly == 6'h1) begin
				r_next.capping = 1'b1;
				r_next.beat = 3'h0;
				r_next.ok = 1'b1;
			end
		end
		if (r_reg.capping) begin
			r_next.cap[r_reg.beat] = r_reg.s2;
			if (r_reg.s2 != r_reg.beat[0]) begin
				r_next.ok = 1'b0;
			end
			r_next.beat = r_reg.beat + 3'h1;
			if (r_reg.beat == last_beat) begin
				r_next.capping = 1'b0;
				if (r_reg.ok && r_reg.s2 == r_reg.beat[0]) begin
					r_next.pass = r_reg.pass + 8'h1;
				end
			end
		end
		if (tick) begin
			r_next.cs_n = 1'b1;
			r_next.ras_n = 1'b1;
			r_next.cas_n = 1'b1;
			r_next.we_n = 1'b1;
			r_next.ba = 3'h0;
			r_next.addr = 14'h0;
			unique case (r_reg.st)
				ddc_pkg::DDC_IDLE: begin
					if (r_reg.op != 3'h0) begin
						r_next.st = ddc_pkg::DDC_PRE;
						r_next.pass = 8'h0;
						r_next.rd_left = r_reg.cfg[`DDC_CFG_NRD_LSB +: 4];
						r_next.a2 = 1'b0;
					end
				end
				ddc_pkg::DDC_PRE: begin
					r_next.cs_n = 1'b0;
					r_next.ras_n = 1'b0;
					r_next.we_n = 1'b0;
					r_next.addr[`DDC_A10_BIT] = 1'b1;
					r_next.cnt = `DDC_T_RP - 10'h1;
					r_next.st = ddc_pkg::DDC_WRP;
				end
				ddc_pkg::DDC_WRP: begin
					if (r_reg.cnt != 10'h0) begin
						r_next.cnt = r_reg.cnt - 10'h1;
					end else if (r_reg.op == `DDC_OP_ZQCL || r_reg.op == `DDC_OP_ZQCS) begin
						r_next.st = ddc_pkg::DDC_ZQ;
					end else begin
						r_next.st = ddc_pkg::DDC_MRS;
					end
				end
				ddc_pkg::DDC_MRS: begin
					r_next.cs_n = 1'b0;
					r_next.ras_n = 1'b0;
					r_next.cas_n = 1'b0;
					r_next.we_n = 1'b0;
					if (r_reg.op == `DDC_OP_CALIB) begin
						r_next.ba = `DDC_MR3_BA;
						r_next.addr[`DDC_MPR_EN_BIT] = ~r_reg.mpr_on;
						r_next.mpr_on = ~r_reg.mpr_on;
					end else begin
						r_next.ba = r_reg.mrs[`DDC_MRS_BA_LSB +: 3];
						r_next.addr = r_reg.mrs[13:0];
					end
					r_next.cnt = `DDC_T_MOD - 10'h1;
					r_next.st = ddc_pkg::DDC_WMOD;
				end
				ddc_pkg::DDC_WMOD: begin
					if (r_reg.cnt != 10'h0) begin
						r_next.cnt = r_reg.cnt - 10'h1;
					end else if (r_reg.mpr_on) begin
						r_next.st = ddc_pkg::DDC_RD;
					end else begin
						r_next.st = ddc_pkg::DDC_IDLE;
						r_next.op = 3'h0;
					end
				end
				ddc_pkg::DDC_RD: begin
					r_next.cs_n = 1'b0;
					r_next.cas_n = 1'b0;
					r_next.addr[2] = bc4 & r_reg.a2;
					r_next.addr[`DDC_A12_BIT] = ~bc4;
					r_next.a2 = ~r_reg.a2;
					r_next.cap_dly = {1'b0, r_reg.cfg[`DDC_CFG_RL_LSB +: 4], 1'b0}
						+ `DDC_CAP_OFS;
					r_next.st = ddc_pkg::DDC_WCAP;
				end
				ddc_pkg::DDC_WCAP: begin
					if (r_reg.cap_dly == 6'h0 && !r_reg.capping) begin
						if (r_reg.rd_left > 4'h1) begin
							r_next.rd_left = r_reg.rd_left - 4'h1;
							r_next.st = ddc_pkg::DDC_RD;
						end else begin
							r_next.cnt = `DDC_T_MPRR - 10'h1;
							r_next.st = ddc_pkg::DDC_WMPRR;
						end
					end
				end
				ddc_pkg::DDC_WMPRR: begin
					if (r_reg.cnt != 10'h0) begin
						r_next.cnt = r_reg.cnt - 10'h1;
					end else begin
						r_next.st = ddc_pkg::DDC_MRS;
					end
				end
				ddc_pkg::DDC_ZQ: begin
					r_next.cs_n = 1'b0;
					r_next.we_n = 1'b0;
					r_next.addr[`DDC_A10_BIT] = (r_reg.op == `DDC_OP_ZQCL);
					r_next.cnt = (r_reg.op == `DDC_OP_ZQCL) ? `DDC_T_ZQOPER - 10'h1
						: `DDC_T_ZQCS - 10'h1;
					r_next.st = ddc_pkg::DDC_WZQ;
				end
				ddc_pkg::DDC_WZQ: begin
					if (r_reg.cnt != 10'h0) begin
						r_next.cnt = r_reg.cnt - 10'h1;
					end else begin
						r_next.st = ddc_pkg::DDC_IDLE;
						r_next.op = 3'h0;
					end
				end
				default: r_next.st = ddc_pkg::DDC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r_reg <= '0;
			r_reg.st <= ddc_pkg::DDC_IDLE;
			r_reg.cke <= 1'b1;
			r_reg.cs_n <= 1'b1;
			r_reg.ras_n <= 1'b1;
			r_reg.cas_n <= 1'b1;
			r_reg.we_n <= 1'b1;
			r_reg.cfg <= `DDC_CFG_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign sw_rdata  = r_reg.rdata;
	assign ddr_ck    = r_reg.ck;
	assign ddr_cke   = r_reg.cke;
	assign ddr_cs_n  = r_reg.cs_n;
	assign ddr_ras_n = r_reg.ras_n;
	assign ddr_cas_n = r_reg.cas_n;
	assign ddr_we_n  = r_reg.we_n;
	assign ddr_ba    = r_reg.ba;
	assign ddr_addr  = r_reg.addr;
	assign ddr_odt   = 1'b0;
	assign ddr_dq_o  = '0;
	assign ddr_dq_oe = 1'b0;

	logic cmd_rd;
	logic cmd_wr;
	logic cmd_mrs;
	logic cmd_pre;
	logic cmd_zq;

	assign cmd_rd  = !ddr_cs_n && ddr_ras_n && !ddr_cas_n && ddr_we_n;
	assign cmd_wr  = !ddr_cs_n && ddr_ras_n && !ddr_cas_n && !ddr_we_n;
	assign cmd_mrs = !ddr_cs_n && !ddr_ras_n && !ddr_cas_n && !ddr_we_n;
	assign cmd_pre = !ddr_cs_n && !ddr_ras_n && ddr_cas_n && !ddr_we_n;
	assign cmd_zq  = !ddr_cs_n && ddr_ras_n && ddr_cas_n && !ddr_we_n;

	property p_rd_addr;
		@(posedge clk) disable iff (!rst_b) cmd_rd |-> ddr_addr[1:0] == 2'h0;
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("Read with A1..A0 nonzero.");

	property p_bl8_a2;
		@(posedge clk) disable iff (!rst_b)
			cmd_rd && ddr_addr[`DDC_A12_BIT] |-> !ddr_addr[2];
	endproperty
	a_bl8_a2: assert property (p_bl8_a2) else $error("BL8 read with A2 set.");

	property p_no_write;
		@(posedge clk) disable iff (!rst_b) !cmd_wr && !ddr_dq_oe;
	endproperty
	a_no_write: assert property (p_no_write) else $error("Write issued.");

	property p_mrs_mr3;
		@(posedge clk) disable iff (!rst_b)
			cmd_mrs && r_reg.op == `DDC_OP_CALIB |->
			ddr_ba == `DDC_MR3_BA && ddr_addr[1:0] == 2'h0
			&& ddr_addr[`DDC_MPR_EN_BIT] == r_reg.mpr_on;
	endproperty
	a_mrs_mr3: assert property (p_mrs_mr3) else $error("Bad MR3 write.");

	property p_pre_gap;
		@(posedge clk) disable iff (!rst_b)
			$rose(cmd_pre) |=> (!cmd_mrs && !cmd_zq)[*8];
	endproperty
	a_pre_gap: assert property (p_pre_gap) else $error("Mode set too soon.");

	property p_mod_gap;
		@(posedge clk) disable iff (!rst_b)
			$rose(cmd_mrs) |=> (!cmd_rd && !cmd_pre && !cmd_zq)[*8];
	endproperty
	a_mod_gap: assert property (p_mod_gap) else $error("Command within mode delay.");

	property p_zq_quiet;
		@(posedge clk) disable iff (!rst_b)
			$rose(cmd_zq) |-> ##2 (ddr_cs_n && ddr_cke && !ddr_odt)[*8];
	endproperty
	a_zq_quiet: assert property (p_zq_quiet) else $error("Activity during ZQ.");

	property p_mpr_only_rd;
		@(posedge clk) disable iff (!rst_b)
			r_reg.mpr_on && !cmd_mrs |-> !cmd_pre && !cmd_zq && !cmd_wr;
	endproperty
	a_mpr_only_rd: assert property (p_mpr_only_rd) else $error("Non-read in MPR.");

	property p_rd_capture;
		@(posedge clk) disable iff (!rst_b)
			$rose(cmd_rd) && r_reg.cfg[3:0] == 4'h7 |-> ##17 r_reg.capping;
	endproperty
	a_rd_capture: assert property (p_rd_capture) else $error("Capture not at RL.");

	property p_rd_mpr;
		@(posedge clk) disable iff (!rst_b) cmd_rd |-> r_reg.mpr_on;
	endproperty
	a_rd_mpr: assert property (p_rd_mpr) else $error("Read outside MPR mode.");

	property p_mpr_exit;
		@(posedge clk) disable iff (!rst_b)
			$fell(r_reg.mpr_on) |-> cmd_mrs && ddr_ba == `DDC_MR3_BA
			&& !ddr_addr[`DDC_MPR_EN_BIT];
	endproperty
	a_mpr_exit: assert property (p_mpr_exit) else $error("MPR left without MR3 clear.");

	property p_cke_odt;
		@(posedge clk) disable iff (!rst_b) ddr_cke && !ddr_odt;
	endproperty
	a_cke_odt: assert property (p_cke_odt) else $error("CKE low or ODT on.");

	c_calib: cover property (@(posedge clk) disable iff (!rst_b)
		$fell(r_reg.mpr_on));
	c_zqcl: cover property (@(posedge clk) disable iff (!rst_b)
		cmd_zq && ddr_addr[`DDC_A10_BIT]);
	c_bc4_hi: cover property (@(posedge clk) disable iff (!rst_b)
		cmd_rd && ddr_addr[2]);
	c_zqcs: cover property (@(posedge clk) disable iff (!rst_b)
		cmd_zq && !ddr_addr[`DDC_A10_BIT]);
endmodule

// *** ddc_map.svh ***
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH
`define DDC_OFS_CTRL    8'h00
`define DDC_OFS_CFG     8'h04
`define DDC_OFS_MRS     8'h08
`define DDC_OFS_STATUS  8'h0C
`define DDC_OP_CALIB    3'h1
`define DDC_OP_ZQCL     3'h2
`define DDC_OP_ZQCS     3'h3
`define DDC_OP_MRS      3'h4
`define DDC_CFG_RL_LSB  0
`define DDC_CFG_BC4_BIT 4
`define DDC_CFG_OTF_BIT 5
`define DDC_CFG_NRD_LSB 8
`define DDC_MRS_BA_LSB  16
`define DDC_CFG_RST     32'h0000_0107
`define DDC_MR3_BA      3'h3
`define DDC_MPR_EN_BIT  2
`define DDC_A10_BIT     10
`define DDC_A12_BIT     12
`define DDC_T_RP        10'h006
`define DDC_T_MOD       10'h00C
`define DDC_T_MPRR      10'h001
`define DDC_T_ZQOPER    10'h100
`define DDC_T_ZQCS      10'h040
`define DDC_CAP_OFS     6'h03
`endif

// *** ddc_pkg.sv ***
package ddc_pkg;
	typedef enum logic [3:0] {
		DDC_IDLE  = 4'h0,
		DDC_PRE   = 4'h1,
		DDC_WRP   = 4'h3,
		DDC_MRS   = 4'h2,
		DDC_WMOD  = 4'h6,
		DDC_RD    = 4'h7,
		DDC_WCAP  = 4'h5,
		DDC_WMPRR = 4'h4,
		DDC_ZQ    = 4'hC,
		DDC_WZQ   = 4'hD
	} ddc_state_t;
	typedef struct packed {
		ddc_state_t  st;
		logic [9:0]  cnt;
		logic        ck;
		logic        cke;
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [2:0]  ba;
		logic [13:0] addr;
		logic [2:0]  op;
		logic [31:0] cfg;
		logic [16:0] mrs;
		logic        mpr_on;
		logic        ok;
		logic [7:0]  cap;
		logic [7:0]  pass;
		logic [3:0]  rd_left;
		logic        a2;
		logic [5:0]  cap_dly;
		logic [2:0]  beat;
		logic        capping;
		logic [31:0] rdata;
		logic        s1;
		logic        s2;
	} ddc_regs_t;
endpackage

// *** ddc_dev_model.sv ***
`timescale 1ns/1ps
`include "ddc_map.svh"
// Device model; RL is the device read latency in clocks and must match the controller setting.
module ddc_dev_model #(
	parameter int DQ_W = 8,
	parameter int RL   = 7
) (
	input  wire logic            clk,
	input  wire logic            rst_b,
	input  wire logic            ck,
	input  wire logic            cke,
	input  wire logic            cs_n,
	input  wire logic [2:0]      cmd,
	input  wire logic [2:0]      ba,
	input  wire logic [13:0]     addr,
	input  wire logic            odt,
	input  wire logic            dq_oe,
	output      logic [DQ_W-1:0] dq
);
	localparam logic [7:0] PAT = 8'hAA;
	logic [13:0] mr [4];
	logic [2:0]  last;
	logic [9:0]  gap;
	logic [9:0]  quiet;
	logic [3:0]  len;
	logic [2:0]  base;
	logic [1:0]  nib_seen;
	logic        zq_long;
	logic        bc4;
	int          t;
	int          errs;
	assign bc4 = (mr[0][1:0] == 2'b01) ? !addr[`DDC_A12_BIT] : (mr[0][1:0] == 2'b10);
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mr <= '{default: 14'h0};
			last <= 3'b111;
			gap <= 10'h3FF;
			quiet <= 10'h0;
			len <= 4'h0;
			nib_seen <= 2'b00;
			zq_long <= 1'b0;
			t <= 1000;
			errs <= 0;
			dq <= '0;
		end else begin
			t <= t + 1;
			dq <= {dq[DQ_W-2:0], ~dq[DQ_W-1]};
			if (t >= 2 * RL && t < 2 * RL + len && mr[3][1:0] == 2'b00)
				dq <= DQ_W'(PAT[base + 3'(t - 2 * RL)]);
			if (quiet != 10'h0 && (!cke || odt || dq_oe))
				errs <= errs + 1;
			if (!ck) begin
				if (gap != 10'h3FF)
					gap <= gap + 10'h1;
				if (quiet != 10'h0)
					quiet <= quiet - 10'h1;
				if (!cs_n) begin
					gap <= 10'h0;
					last <= cmd;
					if (quiet != 10'h0 || (last == 3'b000 && gap + 1 < `DDC_T_MOD))
						errs <= errs + 1;
					case (cmd)
						3'b000: begin
							if (!(last == 3'b010 && gap + 1 >= `DDC_T_RP)
								&& !(last == 3'b101 && mr[3][2]))
								errs <= errs + 1;
							if (!ba[2])
								mr[ba[1:0]] <= addr;
						end
						3'b110: begin
							if (!(last == 3'b010 && gap + 1 >= `DDC_T_RP))
								errs <= errs + 1;
							quiet <= addr[`DDC_A10_BIT] ? `DDC_T_ZQOPER : `DDC_T_ZQCS;
							zq_long <= addr[`DDC_A10_BIT];
						end
						3'b101: begin
							if (!mr[3][2] || addr[1:0] != 2'b00 || (!bc4 && addr[2]))
								errs <= errs + 1;
							t <= 1;
							len <= bc4 ? 4'h4 : 4'h8;
							base <= bc4 ? {addr[2], 2'b00} : 3'h0;
							if (bc4)
								nib_seen[addr[2]] <= 1'b1;
						end
						default: if (mr[3][2]) errs <= errs + 1;
					endcase
				end
			end
		end
	end
endmodule

// *** ddc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`include "ddc_map.svh"
module ddc_ctrl_tb_top;
	logic        clk;
	logic        rst_b;
	logic [7:0]  sw_addr;
	logic [31:0] sw_wdata;
	logic        sw_wr;
	logic        sw_rd;
	logic [31:0] sw_rdata;
	logic        ck;
	logic        cke;
	logic        cs_n;
	logic [2:0]  cmd;
	logic [2:0]  ba;
	logic [13:0] addr;
	logic        odt;
	logic [7:0]  dq_i;
	logic [7:0]  dq_o;
	logic        dq_oe;
	logic [31:0] s;
	int          miscompares;
	int          checks_done;
	always #5 clk = ~clk;
	ddc_ctrl #(.DQ_W(8)) u_dut (
		.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ddr_ck(ck), .ddr_cke(cke),
		.ddr_cs_n(cs_n), .ddr_ras_n(cmd[2]), .ddr_cas_n(cmd[1]), .ddr_we_n(cmd[0]),
		.ddr_ba(ba), .ddr_addr(addr), .ddr_odt(odt), .ddr_dq_i(dq_i), .ddr_dq_o(dq_o),
		.ddr_dq_oe(dq_oe)
	);
	ddc_dev_model #(.DQ_W(8), .RL(7)) u_dev (
		.clk(clk), .rst_b(rst_b), .ck(ck), .cke(cke), .cs_n(cs_n), .cmd(cmd), .ba(ba),
		.addr(addr), .odt(odt), .dq_oe(dq_oe), .dq(dq_i)
	);
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk);
		sw_rd <= 1'b0;
		@(negedge clk);
		s = sw_rdata;
	endtask
	task automatic run_op(input logic [2:0] op);
		wr(`DDC_OFS_CTRL, 32'(op));
		rd(`DDC_OFS_STATUS);
		chk(32'(s[0]), 32'h1);
	endtask
	task automatic idle();
		int n;
		n = 0;
		while (s[0] !== 1'b0) begin
			if (n == 2000) begin
				miscompares++;
				$display("BAD t=%0t got=%h exp=%h", $time, s, 32'h0);
				complete_run();
			end
			n++;
			rd(`DDC_OFS_STATUS);
		end
	endtask
	task automatic t_reset();
		rd(`DDC_OFS_CFG);
		chk(s, `DDC_CFG_RST);
		rd(`DDC_OFS_STATUS);
		chk(s, 32'h0);
		rd(8'h10);
		chk(s, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_bl8();
		run_op(`DDC_OP_CALIB);
		idle();
		rd(`DDC_OFS_STATUS);
		chk(s, {13'h0, 8'h01, 8'hAA, 3'b100});
		chk(32'(u_dev.len), 32'h8);
		$display("test bl8 done");
	endtask
	task automatic t_bc4();
		wr(`DDC_OFS_MRS, 32'h0000_0001);
		rd(`DDC_OFS_MRS);
		chk(s, 32'h0000_0001);
		run_op(`DDC_OP_MRS);
		idle();
		chk(32'(u_dev.mr[0]), 32'h1);
		wr(`DDC_OFS_CFG, 32'h0000_0337);
		run_op(`DDC_OP_CALIB);
		idle();
		rd(`DDC_OFS_STATUS);
		chk(32'({s[18:11], s[6:0]}), 32'({8'h03, 4'hA, 3'b100}));
		chk(32'(u_dev.len), 32'h4);
		chk(32'(u_dev.nib_seen), 32'h3);
		$display("test bc4 done");
	endtask
	task automatic t_zq(input logic [2:0] op);
		run_op(op);
		wr(`DDC_OFS_CFG, `DDC_CFG_RST);
		idle();
		rd(`DDC_OFS_CFG);
		chk(s, 32'h0000_0337);
		rd(`DDC_OFS_CTRL);
		chk(s, 32'h0);
		chk(32'(u_dev.zq_long), 32'(op == `DDC_OP_ZQCL));
		$display("test zq done");
	endtask
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		sw_addr = 8'h00;
		sw_wdata = 32'h0;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		miscompares = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_bl8();
		t_bc4();
		t_zq(`DDC_OP_ZQCL);
		t_zq(`DDC_OP_ZQCS);
		chk(32'(dq_o), 32'h0);
		chk(32'(u_dev.errs), 32'h0);
		complete_run();
	end
endmodule
